// [itbg_top.sv]
// Purpose: three-channel interval timer, event counter and baud clock generator
// Assumes: host i/o bus strobes are synchronous to sys_clk_i; event and gate pins are asynchronous
// Notes: channel 2 output is the serial baud clock
`timescale 1ns/1ps
module itbg_top
  import itbg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_sel_o,
  input wire logic [5:0] ref_sel_i,
  input wire logic [2:0] event_sel_i,
  input wire logic cascade_i,
  input wire logic [2:0] event_pin_i,
  input wire logic [2:0] gate_pin_i,
  output logic [2:0] timer_out_o,
  output logic baud_clk_o
);
  localparam int NCH = 3;

  ////////////////////////////////////////////////////////////////////////
  // reference rate generators
  logic [23:0] acc_q [3];
  logic [23:0] acc_d [3];
  logic [2:0] ref_tick_q, ref_tick_d;
  logic [23:0] step [3];
  assign step[0] = ITBG_STEP0;
  assign step[1] = ITBG_STEP1;
  assign step[2] = ITBG_STEP2;

  always_comb begin
    for (int r = 0; r < 3; r++) begin
      {ref_tick_d[r], acc_d[r]} = {1'b0, acc_q[r]} + {1'b0, step[r]};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      for (int r = 0; r < 3; r++) begin
        acc_q[r] <= 24'h000000;
      end
      ref_tick_q <= 3'h0;
    end else begin
      acc_q <= acc_d;
      ref_tick_q <= ref_tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detect
  logic [2:0] ev_s1_q, ev_s2_q, ev_s3_q;
  logic [2:0] gt_s1_q, gt_s2_q, gt_s3_q;
  logic [5:0] rs_s1_q, rs_s2_q;
  logic [2:0] es_s1_q, es_s2_q;
  logic cs_s1_q, cs_s2_q;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ev_s1_q <= 3'h0;
      ev_s2_q <= 3'h0;
      ev_s3_q <= 3'h0;
      gt_s1_q <= 3'h0;
      gt_s2_q <= 3'h0;
      gt_s3_q <= 3'h0;
      rs_s1_q <= 6'h00;
      rs_s2_q <= 6'h00;
      es_s1_q <= 3'h0;
      es_s2_q <= 3'h0;
      cs_s1_q <= 1'b0;
      cs_s2_q <= 1'b0;
    end else begin
      ev_s1_q <= event_pin_i;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
      gt_s1_q <= gate_pin_i;
      gt_s2_q <= gt_s1_q;
      gt_s3_q <= gt_s2_q;
      rs_s1_q <= ref_sel_i;
      rs_s2_q <= rs_s1_q;
      es_s1_q <= event_sel_i;
      es_s2_q <= es_s1_q;
      cs_s1_q <= cascade_i;
      cs_s2_q <= cs_s1_q;
    end
  end

  // event edges are caught one per system clock, far above the allowed event rate
  logic [2:0] ev_edge, gt_rise;
  assign ev_edge = ev_s2_q & ~ev_s3_q;
  assign gt_rise = gt_s2_q & ~gt_s3_q;

  ////////////////////////////////////////////////////////////////////////
  // host register access
  logic [5:0] mode_q [NCH], mode_d [NCH];
  logic [NCH-1:0] lsb_next_q, lsb_next_d;
  logic [NCH-1:0] rd_msb_q, rd_msb_d;
  logic [NCH-1:0] latched_q, latched_d;
  logic [15:0] latch_q [NCH], latch_d [NCH];
  logic [7:0] lo_byte_q [NCH], lo_byte_d [NCH];
  logic [7:0] rdata_q, rdata_d;
  logic [NCH-1:0] load;
  logic [15:0] load_val [NCH];
  logic [15:0] cnt [NCH];
  logic [NCH-1:0] ch_clk, ch_out;

  function automatic int addr_ch(input logic [7:0] a);
    return (a == ITBG_ADDR_CH0) ? 0 : (a == ITBG_ADDR_CH1) ? 1 : (a == ITBG_ADDR_CH2) ? 2 : 3;
  endfunction

  always_comb begin
    int ch;
    int sel;
    logic [1:0] rl;
    rl = 2'h0;
    ch = addr_ch(io_addr_i);
    sel = int'(io_wdata_i[ITBG_CW_SEL_POS +: 2]);
    mode_d = mode_q;
    lsb_next_d = lsb_next_q;
    rd_msb_d = rd_msb_q;
    latched_d = latched_q;
    latch_d = latch_q;
    lo_byte_d = lo_byte_q;
    rdata_d = rdata_q;
    load = '0;
    for (int c = 0; c < NCH; c++) begin
      load_val[c] = 16'h0000;
    end
    if (io_wr_i && io_addr_i == ITBG_ADDR_CTRL && sel < NCH) begin
      if (io_wdata_i[ITBG_CW_RL_POS +: 2] == ITBG_RL_LATCH) begin
        latched_d[sel] = 1'b1;
        latch_d[sel] = cnt[sel];
      end else begin
        mode_d[sel] = io_wdata_i[5:0];
        lsb_next_d[sel] = 1'b1;
        rd_msb_d[sel] = 1'b0;
      end
    end else if (io_wr_i && ch < NCH) begin
      rl = mode_q[ch][ITBG_CW_RL_POS +: 2];
      unique case (rl)
        ITBG_RL_LSB: begin
          load[ch] = 1'b1;
          load_val[ch] = {8'h00, io_wdata_i};
        end
        ITBG_RL_MSB: begin
          load[ch] = 1'b1;
          load_val[ch] = {io_wdata_i, 8'h00};
        end
        default: begin
          // low byte first, count is used only when the high byte arrives
          if (lsb_next_q[ch]) begin
            lo_byte_d[ch] = io_wdata_i;
            lsb_next_d[ch] = 1'b0;
          end else begin
            load[ch] = 1'b1;
            load_val[ch] = {io_wdata_i, lo_byte_q[ch]};
            lsb_next_d[ch] = 1'b1;
          end
        end
      endcase
    // a write in the same cycle takes priority over the read
    end else if (io_rd_i && !io_wr_i && ch < NCH) begin
      rl = mode_q[ch][ITBG_CW_RL_POS +: 2];
      // live count unless a latch is pending
      rdata_d = latched_q[ch] ? latch_q[ch][7:0] : cnt[ch][7:0];
      if (rl == ITBG_RL_MSB || (rl == ITBG_RL_BOTH && rd_msb_q[ch])) begin
        rdata_d = latched_q[ch] ? latch_q[ch][15:8] : cnt[ch][15:8];
      end
      if (rl == ITBG_RL_BOTH) begin
        rd_msb_d[ch] = ~rd_msb_q[ch];
        latched_d[ch] = latched_q[ch] & ~rd_msb_q[ch];
      end else begin
        latched_d[ch] = 1'b0;
      end
    end else if (io_rd_i && !io_wr_i && io_addr_i == ITBG_ADDR_CTRL) begin
      rdata_d = {2'h0, mode_q[0]};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      for (int c = 0; c < NCH; c++) begin
        mode_q[c] <= {ITBG_RL_BOTH, ITBG_MODE_RESET, 1'b0};
        latch_q[c] <= ITBG_COUNT_RESET;
        lo_byte_q[c] <= 8'h00;
      end
      lsb_next_q <= '1;
      rd_msb_q <= '0;
      latched_q <= '0;
      rdata_q <= 8'h00;
    end else begin
      mode_q <= mode_d;
      lsb_next_q <= lsb_next_d;
      rd_msb_q <= rd_msb_d;
      latched_q <= latched_d;
      latch_q <= latch_d;
      lo_byte_q <= lo_byte_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channel clock selection and channels
  logic ch0_out_q, cascade_tick;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ch0_out_q <= 1'b1;
    end else begin
      ch0_out_q <= ch_out[0];
    end
  end

  assign cascade_tick = ch_out[0] & ~ch0_out_q;

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      logic [1:0] rs;
      rs = rs_s2_q[c*2 +: 2];
      ch_clk[c] = (rs == 2'h0) ? ref_tick_q[0] : (rs == 2'h1) ? ref_tick_q[1] : ref_tick_q[2];
      if (es_s2_q[c]) begin
        ch_clk[c] = ev_edge[c];
      end
    end
    if (cs_s2_q) begin
      ch_clk[1] = cascade_tick;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    itbg_channel u_ch (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .clk_en_i(ch_clk[g]),
      .gate_rise_i(gt_rise[g]),
      .load_i(load[g]),
      .count_i(load_val[g]),
      .mode_i(mode_q[g][ITBG_CW_MODE_POS +: 3]),
      .bcd_i(mode_q[g][ITBG_CW_BCD_POS]),
      .count_o(cnt[g]),
      .out_o(ch_out[g])
    );
  end

  assign io_rdata_o = rdata_q;
  assign io_sel_o = (io_addr_i[7:2] == ITBG_ADDR_CH0[7:2]);
  assign timer_out_o = ch_out;
  assign baud_clk_o = ch_out[2];
endmodule

// [itbg_pkg.sv]
// Purpose: shared constants for the interval timer and baud generator
// Assumes: byte-wide host i/o bus, 100 MHz system clock
// Notes: reference rates are derived from the system clock by fractional accumulators
package itbg_pkg;
  localparam logic [7:0] ITBG_ADDR_CH0 = 8'hDC;
  localparam logic [7:0] ITBG_ADDR_CH1 = 8'hDD;
  localparam logic [7:0] ITBG_ADDR_CH2 = 8'hDE;
  localparam logic [7:0] ITBG_ADDR_CTRL = 8'hDF;
  // control word fields
  localparam int ITBG_CW_SEL_POS = 6;
  localparam int ITBG_CW_RL_POS = 4;
  localparam int ITBG_CW_MODE_POS = 1;
  localparam int ITBG_CW_BCD_POS = 0;
  localparam logic [1:0] ITBG_RL_LATCH = 2'h0;
  localparam logic [1:0] ITBG_RL_LSB = 2'h1;
  localparam logic [1:0] ITBG_RL_MSB = 2'h2;
  localparam logic [1:0] ITBG_RL_BOTH = 2'h3;
  localparam logic [2:0] ITBG_MODE_RESET = 3'h0;
  localparam logic [15:0] ITBG_COUNT_RESET = 16'h0000;
  // system clock and reference rates in hz
  localparam int ITBG_SYS_HZ = 100000000;
  localparam int ITBG_REF0_HZ = 2460000;
  localparam int ITBG_REF1_HZ = 1230000;
  localparam int ITBG_REF2_HZ = 153600;
  localparam int ITBG_EVENT_MAX_HZ = 2460000;
  // accumulator step per system clock: ref/sys scaled by 2^24
  localparam logic [23:0] ITBG_STEP0 = 24'((64'(ITBG_REF0_HZ) << 24) / 64'(ITBG_SYS_HZ));
  localparam logic [23:0] ITBG_STEP1 = 24'((64'(ITBG_REF1_HZ) << 24) / 64'(ITBG_SYS_HZ));
  localparam logic [23:0] ITBG_STEP2 = 24'((64'(ITBG_REF2_HZ) << 24) / 64'(ITBG_SYS_HZ));
  typedef enum logic [2:0] {
    ITBG_M_TC_INT,
    ITBG_M_ONE_SHOT,
    ITBG_M_RATE,
    ITBG_M_SQUARE,
    ITBG_M_SW_STROBE,
    ITBG_M_HW_STROBE
  } itbg_mode_t;
endpackage

// [itbg_channel.sv]
// Purpose: one 16-bit down-counting channel
// Assumes: clk_en_i is a one-cycle pulse per input count, load_i a one-cycle pulse
// Notes: output is a registered level
`timescale 1ns/1ps
module itbg_channel
  import itbg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire logic gate_rise_i,
  input wire logic load_i,
  input wire logic [15:0] count_i,
  input wire logic [2:0] mode_i,
  input wire logic bcd_i,
  output logic [15:0] count_o,
  output logic out_o
);
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] reload_q, reload_d;
  logic run_q, run_d;
  logic out_q, out_d;
  logic first_q, first_d;

  function automatic logic [15:0] dec(input logic [15:0] v, input logic b, input logic [1:0] n);
    logic [15:0] r;
    r = v;
    for (int i = 0; i < 2; i++) begin
      if (i < int'(n)) begin
        if (!b) begin
          r = r - 16'h0001;
        end else begin
          for (int d = 0; d < 4; d++) begin
            if (r[d*4 +: 4] != 4'h0) begin
              r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
              break;
            end
            r[d*4 +: 4] = 4'h9;
          end
        end
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    cnt_d = cnt_q;
    reload_d = reload_q;
    run_d = run_q;
    out_d = out_q;
    first_d = first_q;
    if (load_i) begin
      reload_d = count_i;
      cnt_d = count_i;
      first_d = 1'b1;
      run_d = (mode_i != 3'(ITBG_M_ONE_SHOT)) && (mode_i != 3'(ITBG_M_HW_STROBE));
      out_d = (mode_i != 3'(ITBG_M_TC_INT)) && (mode_i != 3'(ITBG_M_ONE_SHOT));
      // software load acts as the one-shot command
      if (mode_i == 3'(ITBG_M_ONE_SHOT)) begin
        run_d = 1'b1;
      end
    end else if (gate_rise_i && (mode_i == 3'(ITBG_M_ONE_SHOT) || mode_i == 3'(ITBG_M_HW_STROBE))) begin
      cnt_d = reload_q;
      run_d = 1'b1;
      out_d = (mode_i == 3'(ITBG_M_HW_STROBE));
    end else if (clk_en_i && run_q) begin
      unique case (mode_i)
        3'(ITBG_M_RATE): begin
          // low for one input cycle at count 1, period n
          if (cnt_q == 16'h0002) begin
            out_d = 1'b0;
            cnt_d = 16'h0001;
          end else if (cnt_q == 16'h0001) begin
            out_d = 1'b1;
            cnt_d = reload_q;
          end else begin
            cnt_d = dec(cnt_q, bcd_i, 2'h1);
          end
        end
        3'(ITBG_M_SQUARE): begin
          // decrement by two; toggle each half, odd counts favour low half
          if (cnt_q <= 16'h0002) begin
            out_d = ~out_q;
            cnt_d = (reload_q[0] && !out_q) ? reload_q - 16'h0001 : reload_q;
            if (reload_q[0] && out_q) begin
              cnt_d = reload_q + 16'h0001;
            end
          end else begin
            cnt_d = dec(cnt_q, bcd_i, 2'h2);
          end
        end
        default: begin
          if (cnt_q == 16'h0001) begin
            cnt_d = 16'h0000;
            if (mode_i == 3'(ITBG_M_SW_STROBE) || mode_i == 3'(ITBG_M_HW_STROBE)) begin
              out_d = first_q ? 1'b0 : 1'b1;
            end else begin
              out_d = 1'b1;
            end
            first_d = 1'b0;
          end else begin
            if (!first_q && (mode_i == 3'(ITBG_M_SW_STROBE) || mode_i == 3'(ITBG_M_HW_STROBE))) begin
              out_d = 1'b1;
              run_d = 1'b0;
            end
            cnt_d = dec(cnt_q, bcd_i, 2'h1);
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt_q <= ITBG_COUNT_RESET;
      reload_q <= ITBG_COUNT_RESET;
      run_q <= 1'b0;
      out_q <= 1'b1;
      first_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      reload_q <= reload_d;
      run_q <= run_d;
      out_q <= out_d;
      first_q <= first_d;
    end
  end

  assign count_o = cnt_q;
  assign out_o = out_q;
endmodule

// [itbg_top_checker.sv]
// Purpose: port checks for the interval timer
// Assumes: one clock, sync reset
// Notes: channel modes tracked from control writes
`timescale 1ns/1ps
module itbg_top_checker
  import itbg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic io_sel_o,
  input wire logic [5:0] ref_sel_i,
  input wire logic [2:0] event_sel_i,
  input wire logic cascade_i,
  input wire logic [2:0] event_pin_i,
  input wire logic [2:0] gate_pin_i,
  input wire logic [2:0] timer_out_o,
  input wire logic baud_clk_o
);
  logic [8:0] mode_q, mode_d;
  logic [9:0] seen_q;
  logic [3:0] quiet_q, quiet_d;
  wire logic [9:0] seen = {event_pin_i, gate_pin_i, event_sel_i, cascade_i};
  ////////////////////////////////////////////////////////////
  always_comb begin
    mode_d = mode_q;
    if (io_wr_i && io_addr_i == ITBG_ADDR_CTRL && io_wdata_i[7:6] != 2'h3 && io_wdata_i[5:4] != 2'h0) begin
      mode_d[io_wdata_i[7:6] * 3 +: 3] = io_wdata_i[3:1];
    end
    // cycles since any write or change on the event, gate, event-select or cascade pins, saturating
    quiet_d = (io_wr_i || seen != seen_q) ? 4'h0 : quiet_q + 4'(quiet_q != 4'hF);
  end
  always_ff @(posedge sys_clk_i) begin
    mode_q <= srst_i ? 9'h000 : mode_d;
    quiet_q <= srst_i ? 4'h0 : quiet_d;
    seen_q <= seen;
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  a_sel_decode: assert property (io_sel_o == (io_addr_i >= ITBG_ADDR_CH0 && io_addr_i <= ITBG_ADDR_CTRL))
    else $error("bad select");
  a_baud_tracks: assert property (baud_clk_o == timer_out_o[2])
    else $error("baud differs");
  a_rdata_hold: assert property (!io_rd_i |=> $stable(io_rdata_o))
    else $error("read data moved");
  a_rd_unmapped: assert property (io_rd_i && !io_sel_o |=> $stable(io_rdata_o))
    else $error("unmapped read answered");
  a_wr_wins: assert property (io_wr_i && io_rd_i |=> $stable(io_rdata_o))
    else $error("read beat write");
  a_events_only: assert property (event_sel_i == 3'h7 && quiet_q > 4'hB |-> $stable(timer_out_o))
    else $error("output moved without event");
  a_rate_returns: assert property (mode_q[2:0] == 3'h2 && $fell(timer_out_o[0]) |-> ##[1:1000] timer_out_o[0])
    else $error("rate pulse stuck low");
  a_square_hold: assert property (mode_q[5:3] == 3'h3 && $rose(timer_out_o[1]) |=> timer_out_o[1] [*8])
    else $error("square half too short");
  a_oneshot_fall: assert property (mode_q[5:3] == 3'h1 && $rose(gate_pin_i[1]) |-> ##[1:8] !timer_out_o[1])
    else $error("trigger did not fall");
endmodule
bind itbg_top itbg_top_checker u_chk (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
  .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .io_sel_o(io_sel_o), .ref_sel_i(ref_sel_i),
  .event_sel_i(event_sel_i), .cascade_i(cascade_i), .event_pin_i(event_pin_i), .gate_pin_i(gate_pin_i),
  .timer_out_o(timer_out_o), .baud_clk_o(baud_clk_o)
);

// [itbg_event_src.sv]
// Purpose: far-side event source for the event pins
// Assumes: one rising edge per 50 cycles while running
// Notes: pins idle low when stopped
`timescale 1ns/1ps
module itbg_event_src (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic run_i,
  input wire logic [2:0] lane_i,
  output logic [2:0] event_pin_o
);
  logic [5:0] ph_q, ph_d;
  always_comb begin
    ph_d = (!run_i || ph_q == 6'h31) ? 6'h00 : ph_q + 6'h01;
  end
  always_ff @(posedge sys_clk_i) begin
    ph_q <= srst_i ? 6'h00 : ph_d;
  end
  // 25 high, 25 low: 2 MHz keeps under the event ceiling
  assign event_pin_o = (run_i && ph_q < 6'h19) ? lane_i : 3'h0;
endmodule

// [itbg_top_tb.sv]
// Purpose: directed bench for the interval timer
// Assumes: events come from the event source model
// Notes: inputs change at the falling edge
`timescale 1ns/1ps
module itbg_top_tb
  import itbg_pkg::*;
;
  logic sys_clk_i = 1'b0, srst_i = 1'b1, io_wr_i = 1'b0, io_rd_i = 1'b0, cascade_i = 1'b0, run = 1'b0;
  logic [7:0] io_addr_i = 8'h00, io_wdata_i = 8'h00, b0, b1, io_rdata_o;
  logic [5:0] ref_sel_i = 6'h00;
  logic [2:0] event_sel_i = 3'h7, gate_pin_i = 3'h0, lane = 3'h1, event_pin_i, timer_out_o;
  logic io_sel_o, baud_clk_o;
  int n_fail = 0, n_compared = 0, lo, t, e;
  always #5 sys_clk_i = ~sys_clk_i;
  itbg_top dut (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
    .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .io_sel_o(io_sel_o), .ref_sel_i(ref_sel_i),
    .event_sel_i(event_sel_i), .cascade_i(cascade_i), .event_pin_i(event_pin_i), .gate_pin_i(gate_pin_i),
    .timer_out_o(timer_out_o), .baud_clk_o(baud_clk_o)
  );
  itbg_event_src u_src (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .run_i(run), .lane_i(lane), .event_pin_o(event_pin_i)
  );
  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    @(negedge sys_clk_i);
    io_wr_i = 1'b0;
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a, v[15:8]);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_i);
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(negedge sys_clk_i);
    io_rd_i = 1'b0;
    d = io_rdata_o;
  endtask
  // n event edges; lo counts low samples of channel c, one per edge
  task automatic ev(input int n, input int c);
    repeat (25) @(negedge sys_clk_i);
    lo = 0;
    run = 1'b1;
    for (int i = 0; i < n * 50 - 25; i++) begin
      @(negedge sys_clk_i);
      if (i % 50 == 20 && timer_out_o[c] === 1'b0) lo++;
    end
    run = 1'b0;
  endtask
  task automatic gate();
    @(negedge sys_clk_i);
    gate_pin_i = 3'h2;
    repeat (8) @(negedge sys_clk_i);
    gate_pin_i = 3'h0;
  endtask
  task automatic fall(output int n);
    logic p;
    p = timer_out_o[0];
    for (n = 1; n < 3000; n++) begin
      @(negedge sys_clk_i);
      if (p === 1'b1 && timer_out_o[0] === 1'b0) return;
      p = timer_out_o[0];
    end
    n_fail++;
    $display("unexpected at %0t: got %h expected %h", $time, 1'b1, 1'b0);
    print_verdict();
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge sys_clk_i);
    srst_i = 1'b0;
    @(negedge sys_clk_i);
    chk(16'({timer_out_o, baud_clk_o, io_rdata_o}), 16'h0F00);
    $display("done: reset");
    for (int a = 8'hDA; a <= 8'hE0; a++) begin
      @(negedge sys_clk_i);
      io_addr_i = 8'(a);
      #1;
      chk(16'(io_sel_o), 16'(a >= 8'hDC && a <= 8'hDF));
    end
    @(negedge sys_clk_i);
    io_addr_i = ITBG_ADDR_CTRL;
    io_wdata_i = 8'hC0;
    io_wr_i = 1'b1;
    io_rd_i = 1'b1;
    @(negedge sys_clk_i);
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
    rd(8'hE0, b0);
    chk(16'(b0), 16'h0000);
    $display("done: decode");
    wr(ITBG_ADDR_CTRL, 8'h34);
    wr16(ITBG_ADDR_CH0, 16'h0003);
    ev(9, 0);
    chk(16'(lo), 16'h0003);
    $display("done: rate");
    lane = 3'h2;
    wr(ITBG_ADDR_CTRL, 8'h76);
    wr16(ITBG_ADDR_CH1, 16'h0004);
    ev(8, 1);
    chk(16'(lo), 16'h0004);
    $display("done: square");
    wr(ITBG_ADDR_CTRL, 8'h72);
    wr16(ITBG_ADDR_CH1, 16'h0002);
    repeat (3) @(negedge sys_clk_i);
    chk(16'(timer_out_o[1]), 16'h0000);
    ev(1, 1);
    gate();
    ev(2, 1);
    chk(16'(lo), 16'h0001);
    gate();
    chk(16'(timer_out_o[1]), 16'h0000);
    $display("done: one-shot");
    lane = 3'h4;
    wr(ITBG_ADDR_CTRL, 8'hB0);
    wr16(ITBG_ADDR_CH2, 16'h0103);
    repeat (3) @(negedge sys_clk_i);
    chk(16'(baud_clk_o), 16'h0000);
    ev(1, 2);
    wr(ITBG_ADDR_CTRL, 8'h80);
    // keep counting after the latch so the live count differs from the latched one
    ev(1, 2);
    rd(ITBG_ADDR_CH2, b0);
    rd(ITBG_ADDR_CH2, b1);
    chk({b1, b0}, 16'h0102);
    ev(256, 2);
    chk(16'(lo), 16'h0100);
    ev(1, 2);
    chk(16'({lo[7:0], baud_clk_o}), 16'h0001);
    $display("done: baud divisor");
    cascade_i = 1'b1;
    event_sel_i = 3'h5;
    lane = 3'h1;
    wr(ITBG_ADDR_CTRL, 8'h34);
    wr16(ITBG_ADDR_CH0, 16'h0002);
    wr(ITBG_ADDR_CTRL, 8'h70);
    wr16(ITBG_ADDR_CH1, 16'h0002);
    ev(4, 1);
    chk(16'(lo), 16'h0003);
    rd(ITBG_ADDR_CTRL, b0);
    chk(16'(b0), 16'h0034);
    $display("done: cascade");
    cascade_i = 1'b0;
    event_sel_i = 3'h0;
    for (int r = 0; r < 3; r++) begin
      ref_sel_i = {3{2'(r)}};
      fall(t);
      fall(t);
      fall(t);
      e = 2 * ITBG_SYS_HZ / (r == 0 ? ITBG_REF0_HZ : r == 1 ? ITBG_REF1_HZ : ITBG_REF2_HZ);
      chk(16'((t > e - 3 && t < e + 3) ? e : t), 16'(e));
    end
    $display("done: reference");
    print_verdict();
  end
endmodule
